// [verilog/aas_pkg.sv]
// Register map, field layout and timing constants of the acquisition sequencer
package aas_pkg;
	// ------------------------------
	// Register offsets
	// ------------------------------
	localparam logic [7:0] OFF_CTRL   = 8'h00;
	localparam logic [7:0] OFF_CMD    = 8'h04;
	localparam logic [7:0] OFF_STATUS = 8'h08;
	localparam logic [7:0] OFF_ISTAT  = 8'h0C;
	localparam logic [7:0] OFF_IMASK  = 8'h10;
	localparam logic [7:0] OFF_COUNT  = 8'h14;
	localparam logic [7:0] OFF_PACE   = 8'h18;
	localparam logic [7:0] OFF_SLEN   = 8'h1C;
	localparam logic [7:0] OFF_DATA   = 8'h20;
	localparam logic [7:0] OFF_REMAIN = 8'h24;
	localparam logic [7:0] OFF_BLOCK  = 8'h28;
	localparam logic [7:0] OFF_SCAN   = 8'h40;
	// ------------------------------
	// Field positions
	// ------------------------------
	localparam int CTRL_W     = 5;
	localparam int CTRL_PEXT  = 2;
	localparam int CTRL_REFEN = 3;
	localparam int CTRL_DMA   = 4;
	localparam int CMD_START  = 0;
	localparam int CMD_STOP   = 1;
	localparam int CMD_CONV   = 2;
	localparam int CMD_BEGIN  = 3;
	localparam int INT_OVF    = 0;
	localparam int INT_DONE   = 1;
	localparam int INT_BLOCK  = 2;
	localparam int INT_SAMPLE = 3;
	localparam int INT_CFG    = 4;
	localparam int INT_W      = 5;
	localparam int PIN_BEGIN  = 0;
	localparam int PIN_SPLIT  = 1;
	localparam int PIN_HOLD   = 2;
	localparam int PIN_PACE   = 3;
	localparam int CH_W       = 4;
	localparam int RNG_LSB    = 4;
	localparam int RNG_W      = 2;
	localparam int ENT_REF    = 6;
	localparam int ENT_W      = 7;
	localparam int CODE_W     = 16;
	localparam int SCNT_W     = 24;
	// ------------------------------
	// Encodings and reset values
	// ------------------------------
	localparam logic [1:0]        MODE_SW     = 2'h0;
	localparam logic [1:0]        MODE_FIN    = 2'h1;
	localparam logic [1:0]        MODE_CONT   = 2'h2;
	localparam logic [1:0]        MODE_NB     = 2'h3;
	localparam logic [CH_W-1:0]   CH_GND_SELF = 4'h8;
	localparam logic              REF_DIFFERENTIAL_INPUT    = 1'b0;
	localparam logic              REF_SE      = 1'b1;
	localparam logic [1:0]        RESP_OKAY   = 2'h0;
	localparam logic [1:0]        RESP_SLVERR = 2'h2;
	localparam logic [SCNT_W-1:0] RST_COUNT   = 24'h000001;
	localparam logic [15:0]       RST_PACE    = 16'h0063;
	localparam logic [ENT_W-1:0]  RST_ENT     = 7'h00;
	// ------------------------------
	// Timing
	// ------------------------------
	localparam int CLK_NS     = 10;
	localparam int SETTLE_NS  = 20;
	localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;

	typedef enum logic [2:0] {ST_IDLE, ST_ARMED, ST_PACE, ST_LOAD, ST_CONV} aas_state_type;
endpackage

// [verilog/aas_sample_fifo.sv]
// Sample FIFO in flip-flops; a write while full drops the oldest word
module aas_sample_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input  wire logic                  clk_i,
	input  wire logic                  srst_i,
	// Write side
	input  wire logic                  push_i,
	input  wire logic [WIDTH-1:0]      data_i,
	// Read side
	input  wire logic                  pop_i,
	output logic      [WIDTH-1:0]      data_o,
	output logic      [$clog2(DEPTH):0] count_o,
	output logic                       full_o,
	output logic                       empty_o
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic             do_pop;

	function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
		return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	assign full_o  = count_o == (AW + 1)'(DEPTH);
	assign empty_o = count_o == '0;
	assign data_o  = mem[rd_ptr];
	assign do_pop  = (pop_i && !empty_o) || (push_i && full_o);

	always_ff @(posedge clk_i) begin
		if (push_i) begin
			mem[wr_ptr] <= data_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			wr_ptr  <= '0;
			rd_ptr  <= '0;
			count_o <= '0;
		end else begin
			if (push_i) begin
				wr_ptr <= inc(wr_ptr);
			end
			if (do_pop) begin
				rd_ptr <= inc(rd_ptr);
			end
			if (push_i && !do_pop) begin
				count_o <= count_o + 1'b1;
			end else if (!push_i && do_pop) begin
				count_o <= count_o - 1'b1;
			end
		end
	end
endmodule

// [verilog/aas_sequencer.sv]
// Acquisition sequencer: register slave, scan list, pacing, triggers, interrupt
//
// Summary of operation
// - Every scan entry has its own ground-reference bit; the reference output follows channel bit 3 and a mismatch flags INT_CFG.
// - Internal channel reads the device's own input ground.
// - Range is loaded into the gain amplifier before each conversion.
// - Host command gives exactly one conversion in software timing.
// - Hardware timing paced by internal divider or external pacing input.
// - Buffered samples leave in blocks by DMA or interrupt.
// - Finite mode stops itself after the preset sample count.
// - Reference trigger allowed only with finite mode.
// - Continuous mode runs until the host stops it.
// - Sample into full FIFO overwrites old data and flags overflow.
// - Non-buffered mode: host reads samples straight from the FIFO.
// - Start, reference and pause trigger actions exist.
// - Triggers come from digital inputs; the start trigger can also be given by the host CMD_BEGIN command.
// - One channel at a time goes to the converter.
// - External channels differential, internal channel single-ended.
// - Each conversion gives a 16-bit code.
// - Sample counter loads request and counts down per pacing pulse.
//
// The AXI4-Lite register port and the placing of the registers were decided locally.
module aas_sequencer import aas_pkg::*; #(
	parameter int SCAN_N     = 8,
	parameter int FIFO_DEPTH = 16
) (
	// Clock and reset
	input  wire logic              clk_i,
	input  wire logic              srst_i,
	// AXI4-Lite slave
	input  wire logic [7:0]        s_axi_awaddr_i,
	input  wire logic              s_axi_awvalid_i,
	output logic                   s_axi_awready_o,
	input  wire logic [31:0]       s_axi_wdata_i,
	input  wire logic [3:0]        s_axi_wstrb_i,
	input  wire logic              s_axi_wvalid_i,
	output logic                   s_axi_wready_o,
	output logic      [1:0]        s_axi_bresp_o,
	output logic                   s_axi_bvalid_o,
	input  wire logic              s_axi_bready_i,
	input  wire logic [7:0]        s_axi_araddr_i,
	input  wire logic              s_axi_arvalid_i,
	output logic                   s_axi_arready_o,
	output logic      [31:0]       s_axi_rdata_o,
	output logic      [1:0]        s_axi_rresp_o,
	output logic                   s_axi_rvalid_o,
	input  wire logic              s_axi_rready_i,
	// Digital trigger and pacing pins
	input  wire logic              acquisition_begin_trigger_i,
	input  wire logic              pre_post_split_trigger_i,
	input  wire logic              acquisition_hold_trigger_i,
	input  wire logic              sample_pacing_clock_i,
	// Multiplexer, gain amplifier and converter
	output logic      [CH_W-1:0]   mux_sel_o,
	output logic      [RNG_W-1:0]  gain_range_o,
	output logic                   reference_mode_setting_o,
	output logic                   gain_load_o,
	output logic                   conv_start_o,
	input  wire logic              conv_done_i,
	input  wire logic [CODE_W-1:0] conv_code_i,
	// Host transfer
	output logic                   dma_req_o,
	output logic                   irq_o
);
	localparam int IDX_W = $clog2(SCAN_N);
	localparam int CNT_W = $clog2(FIFO_DEPTH) + 1;

	// ------------------------------
	// Declarations
	// ------------------------------
	logic              aw_held, w_held, do_wr;
	logic [7:0]        aw_addr;
	logic [31:0]       w_data, rd_mux;
	logic [3:0]        w_strb, cmd;
	logic [CTRL_W-1:0] ctrl;
	logic [1:0]        mode;
	logic [INT_W-1:0]  int_stat, int_mask, clr, ev;
	logic [SCNT_W-1:0] sample_cnt, remain;
	logic [15:0]       pace_div, pace_cnt;
	logic [IDX_W:0]    scan_len;
	logic [CNT_W-1:0]  block_size, fifo_cnt;
	logic [ENT_W-1:0]  scan_ent [SCAN_N];
	logic [ENT_W-1:0]  nxt_ent;
	aas_state_type     state;
	logic [IDX_W-1:0]  ent_idx, nxt_idx;
	logic [3:0]        settle;
	logic              single, split_seen, stop_pend;
	logic              buffered, counting, pace_pulse, last_ent, conv_end;
	logic              fin_done, start_bad, go_load, slen_wr, push, pop, full, empty;
	logic [CODE_W-1:0] fifo_data;
	logic [3:0]        pin_raw, pin_hi, pin_rise;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] m;
		m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
		return (old & ~m) | (d & m);
	endfunction

	function automatic logic is_scan(input logic [7:0] a);
		return a >= OFF_SCAN && a < OFF_SCAN + 8'(4 * SCAN_N) && a[1:0] == 2'h0;
	endfunction

	// ------------------------------
	// Pin synchronisers
	// ------------------------------
	assign pin_raw = {sample_pacing_clock_i, acquisition_hold_trigger_i,
		pre_post_split_trigger_i, acquisition_begin_trigger_i};

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_pin
			logic [2:0] q;
			logic       lvl;
			always_ff @(posedge clk_i) begin
				if (srst_i) begin
					q   <= 3'h0;
					lvl <= 1'b0;
				end else begin
					q <= {q[1:0], pin_raw[g]};
					if (q[1] == q[2]) begin
						lvl <= q[2];
					end
				end
			end
			assign pin_hi[g]   = lvl;
			assign pin_rise[g] = q[1] && q[2] && !lvl;
		end
	endgenerate

	// ------------------------------
	// Register bus
	// ------------------------------
	assign do_wr   = aw_held && w_held && !s_axi_bvalid_o;
	assign cmd     = (do_wr && aw_addr == OFF_CMD && w_strb[0]) ? w_data[3:0] : 4'h0;
	assign clr     = (do_wr && aw_addr == OFF_ISTAT && w_strb[0]) ? w_data[INT_W-1:0] : '0;
	assign slen_wr = do_wr && aw_addr == OFF_SLEN;
	assign pop     = s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == OFF_DATA
		&& !empty;

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			aw_held         <= 1'b0;
			w_held          <= 1'b0;
			aw_addr         <= 8'h00;
			w_data          <= 32'h0000_0000;
			w_strb          <= 4'h0;
			s_axi_awready_o <= 1'b0;
			s_axi_wready_o  <= 1'b0;
			s_axi_bvalid_o  <= 1'b0;
			s_axi_bresp_o   <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				aw_held         <= 1'b1;
				aw_addr         <= s_axi_awaddr_i;
				s_axi_awready_o <= 1'b0;
			end else if (!aw_held && !s_axi_bvalid_o) begin
				s_axi_awready_o <= 1'b1;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				w_held         <= 1'b1;
				w_data         <= s_axi_wdata_i;
				w_strb         <= s_axi_wstrb_i;
				s_axi_wready_o <= 1'b0;
			end else if (!w_held && !s_axi_bvalid_o) begin
				s_axi_wready_o <= 1'b1;
			end
			if (do_wr) begin
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o  <= (is_scan(aw_addr) || (aw_addr <= OFF_BLOCK
					&& aw_addr[1:0] == 2'h0)) ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bvalid_o && s_axi_bready_i) begin
				s_axi_bvalid_o <= 1'b0;
				aw_held        <= 1'b0;
				w_held         <= 1'b0;
			end
		end
	end

	always_comb begin
		rd_mux = 32'h0000_0000;
		case (s_axi_araddr_i)
			OFF_CTRL:   rd_mux = 32'(ctrl);
			OFF_STATUS: rd_mux = {16'h0000, 8'(fifo_cnt), 4'h0, split_seen, full, empty,
				state != ST_IDLE};
			OFF_ISTAT:  rd_mux = 32'(int_stat);
			OFF_IMASK:  rd_mux = 32'(int_mask);
			OFF_COUNT:  rd_mux = 32'(sample_cnt);
			OFF_PACE:   rd_mux = 32'(pace_div);
			OFF_SLEN:   rd_mux = 32'(scan_len);
			OFF_DATA:   rd_mux = empty ? 32'h0000_0000 : 32'(fifo_data);
			OFF_REMAIN: rd_mux = 32'(remain);
			OFF_BLOCK:  rd_mux = 32'(block_size);
			default: begin
				if (is_scan(s_axi_araddr_i)) begin
					rd_mux = 32'(scan_ent[s_axi_araddr_i[IDX_W+1:2]]);
				end
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o  <= 1'b0;
			s_axi_rdata_o   <= 32'h0000_0000;
			s_axi_rresp_o   <= RESP_OKAY;
		end else if (s_axi_arvalid_i && s_axi_arready_o) begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o  <= 1'b1;
			s_axi_rdata_o   <= rd_mux;
			s_axi_rresp_o   <= (is_scan(s_axi_araddr_i) || (s_axi_araddr_i <= OFF_BLOCK
				&& s_axi_araddr_i[1:0] == 2'h0)) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rvalid_o && s_axi_rready_i) begin
			s_axi_rvalid_o <= 1'b0;
		end else if (!s_axi_rvalid_o) begin
			s_axi_arready_o <= 1'b1;
		end
	end

	// ------------------------------
	// Configuration registers
	// ------------------------------
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			ctrl       <= '0;
			int_mask   <= '0;
			sample_cnt <= RST_COUNT;
			pace_div   <= RST_PACE;
			scan_len   <= (IDX_W + 1)'(1);
			block_size <= CNT_W'(FIFO_DEPTH / 2);
			for (int i = 0; i < SCAN_N; i++) begin
				scan_ent[i] <= RST_ENT;
			end
		end else if (do_wr) begin
			if (aw_addr == OFF_CTRL) ctrl <= CTRL_W'(merge(32'(ctrl), w_data, w_strb));
			if (aw_addr == OFF_IMASK) int_mask <= INT_W'(merge(32'(int_mask), w_data, w_strb));
			if (aw_addr == OFF_COUNT) sample_cnt <= SCNT_W'(merge(32'(sample_cnt), w_data, w_strb));
			if (aw_addr == OFF_PACE) pace_div <= 16'(merge(32'(pace_div), w_data, w_strb));
			if (aw_addr == OFF_BLOCK) block_size <= CNT_W'(merge(32'(block_size), w_data, w_strb));
			if (slen_wr && w_data != 32'h0 && w_data <= 32'(SCAN_N) && w_strb[0]) begin
				scan_len <= (IDX_W + 1)'(w_data);
			end
			if (is_scan(aw_addr)) begin
				scan_ent[aw_addr[IDX_W+1:2]] <= ENT_W'(merge(32'(scan_ent[aw_addr[IDX_W+1:2]]),
					w_data, w_strb));
			end
		end
	end

	// ------------------------------
	// Sequencer
	// ------------------------------
	assign mode       = ctrl[1:0];
	assign buffered   = mode == MODE_FIN || mode == MODE_CONT;
	assign counting   = mode == MODE_FIN && (!ctrl[CTRL_REFEN] || split_seen);
	assign pace_pulse = ctrl[CTRL_PEXT] ? pin_rise[PIN_PACE] : pace_cnt == 16'h0000;
	assign last_ent   = ent_idx == IDX_W'(scan_len - 1'b1);
	assign conv_end   = state == ST_CONV && conv_done_i;
	assign fin_done   = conv_end && !single && last_ent && counting && remain == '0;
	assign start_bad  = mode == MODE_SW || (ctrl[CTRL_REFEN] && mode != MODE_FIN)
		|| (mode == MODE_FIN && sample_cnt == '0);
	assign go_load    = (state == ST_IDLE && cmd[CMD_CONV] && mode == MODE_SW)
		|| (state == ST_PACE && pace_pulse && !pin_hi[PIN_HOLD] && !cmd[CMD_STOP])
		|| (conv_end && !single && !last_ent && !stop_pend && !cmd[CMD_STOP]);
	assign nxt_idx    = (state == ST_PACE) ? '0 : (state == ST_CONV) ? ent_idx + 1'b1 : ent_idx;
	assign nxt_ent    = scan_ent[nxt_idx];

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			state      <= ST_IDLE;
			ent_idx    <= '0;
			settle     <= 4'h0;
			single     <= 1'b0;
			split_seen <= 1'b0;
			stop_pend  <= 1'b0;
			remain     <= '0;
		end else begin
			unique case (state)
				ST_IDLE: begin
					if (cmd[CMD_START] && !start_bad) begin
						state      <= ST_ARMED;
						remain     <= sample_cnt;
						split_seen <= 1'b0;
						stop_pend  <= 1'b0;
						ent_idx    <= '0;
					end else if (go_load) begin
						state  <= ST_LOAD;
						single <= 1'b1;
						settle <= 4'(SETTLE_CYC);
					end else if (slen_wr) begin
						ent_idx <= '0;
					end
				end
				ST_ARMED: begin
					if (cmd[CMD_STOP]) begin
						state <= ST_IDLE;
					end else if (pin_rise[PIN_BEGIN] || cmd[CMD_BEGIN]) begin
						state <= ST_PACE;
					end
				end
				ST_PACE: begin
					if (cmd[CMD_STOP]) begin
						state <= ST_IDLE;
					end else if (go_load) begin
						state   <= ST_LOAD;
						single  <= 1'b0;
						ent_idx <= '0;
						settle  <= 4'(SETTLE_CYC);
						if (counting) remain <= remain - 1'b1;
					end
				end
				ST_LOAD: begin
					if (settle == 4'h0) state <= ST_CONV;
					else settle <= settle - 1'b1;
				end
				ST_CONV: begin
					if (conv_done_i) begin
						if (single) begin
							state   <= ST_IDLE;
							ent_idx <= last_ent ? '0 : ent_idx + 1'b1;
						end else if (go_load) begin
							state   <= ST_LOAD;
							ent_idx <= nxt_idx;
							settle  <= 4'(SETTLE_CYC);
						end else if (stop_pend || cmd[CMD_STOP] || fin_done) begin
							state <= ST_IDLE;
						end else begin
							state <= ST_PACE;
						end
					end
				end
			endcase
			if (cmd[CMD_STOP] && state != ST_IDLE) stop_pend <= 1'b1;
			if (state != ST_IDLE && ctrl[CTRL_REFEN] && pin_rise[PIN_SPLIT]) split_seen <= 1'b1;
		end
	end

	// Internal pacing divider, period pace_div + 1
	always_ff @(posedge clk_i) begin
		if (srst_i || state == ST_IDLE || state == ST_ARMED || pace_cnt == 16'h0000) begin
			pace_cnt <= srst_i ? RST_PACE : pace_div;
		end else begin
			pace_cnt <= pace_cnt - 1'b1;
		end
	end

	// ------------------------------
	// Converter side
	// ------------------------------
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			mux_sel_o                <= CH_GND_SELF;
			gain_range_o             <= '0;
			reference_mode_setting_o <= REF_SE;
			gain_load_o              <= 1'b0;
			conv_start_o             <= 1'b0;
		end else begin
			gain_load_o  <= go_load;
			conv_start_o <= state == ST_LOAD && settle == 4'h0;
			if (go_load) begin
				mux_sel_o    <= nxt_ent[CH_W-1:0];
				gain_range_o <= nxt_ent[RNG_LSB +: RNG_W];
				reference_mode_setting_o <= nxt_ent[CH_W-1] ? REF_SE : REF_DIFFERENTIAL_INPUT;
			end
		end
	end

	// ------------------------------
	// Sample FIFO, events and host requests
	// ------------------------------
	assign push = conv_end;

	aas_sample_fifo #(.WIDTH(CODE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk_i   (clk_i),
		.srst_i  (srst_i),
		.push_i  (push),
		.data_i  (conv_code_i),
		.pop_i   (pop),
		.data_o  (fifo_data),
		.count_o (fifo_cnt),
		.full_o  (full),
		.empty_o (empty)
	);

	assign ev[INT_OVF]    = push && full && !pop;
	assign ev[INT_DONE]   = fin_done;
	assign ev[INT_BLOCK]  = push && !pop && buffered && !ctrl[CTRL_DMA]
		&& fifo_cnt == block_size - 1'b1;
	assign ev[INT_SAMPLE] = push && single;
	assign ev[INT_CFG]    = (state == ST_IDLE && cmd[CMD_START] && start_bad)
		|| (go_load && nxt_ent[ENT_REF] != nxt_ent[CH_W-1]);

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			int_stat  <= '0;
			irq_o     <= 1'b0;
			dma_req_o <= 1'b0;
		end else begin
			int_stat  <= (int_stat & ~clr) | ev;
			irq_o     <= |(int_stat & int_mask);
			dma_req_o <= ctrl[CTRL_DMA] && buffered && fifo_cnt >= block_size;
		end
	end

	// ------------------------------
	// Assertions
	// ------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);

	property p_gain_first;
		gain_load_o |-> ##1 !conv_start_o [*2] ##1 conv_start_o;
	endproperty
	a_gain_first: assert property (p_gain_first)
		else $error("conversion not three cycles after gain load");

	property p_one_conv;
		(state == ST_IDLE && cmd[CMD_CONV] && mode == MODE_SW) |=> single ##3 conv_start_o;
	endproperty
	a_one_conv: assert property (p_one_conv)
		else $error("software command did not start a conversion");

	property p_finite_end;
		fin_done |=> state == ST_IDLE && int_stat[INT_DONE];
	endproperty
	a_finite_end: assert property (p_finite_end)
		else $error("finite run did not stop");

	property p_ref_refused;
		(state == ST_IDLE && cmd[CMD_START] && ctrl[CTRL_REFEN] && mode != MODE_FIN)
			|=> state != ST_ARMED && int_stat[INT_CFG];
	endproperty
	a_ref_refused: assert property (p_ref_refused)
		else $error("reference trigger accepted outside finite mode");

	property p_cont_runs;
		(conv_end && mode == MODE_CONT && !stop_pend && !cmd[CMD_STOP]) |=> state != ST_IDLE;
	endproperty
	a_cont_runs: assert property (p_cont_runs)
		else $error("continuous run ended without stop");

	property p_overflow;
		ev[INT_OVF] |=> int_stat[INT_OVF] && fifo_cnt == CNT_W'(FIFO_DEPTH);
	endproperty
	a_overflow: assert property (p_overflow)
		else $error("overflow not flagged");

	property p_ovf_sticky;
		(int_stat[INT_OVF] && !clr[INT_OVF]) |=> int_stat[INT_OVF];
	endproperty
	a_ovf_sticky: assert property (p_ovf_sticky)
		else $error("overflow flag lost");

	property p_hold;
		(state == ST_PACE && pin_hi[PIN_HOLD] && !cmd[CMD_STOP]) |=> state == ST_PACE;
	endproperty
	a_hold: assert property (p_hold)
		else $error("pacing pulse taken during hold");

	property p_mux_steady;
		state == ST_CONV |-> $stable(mux_sel_o) && $stable(gain_range_o);
	endproperty
	a_mux_steady: assert property (p_mux_steady)
		else $error("channel changed during conversion");

	property p_ref_kind;
		conv_start_o |-> reference_mode_setting_o == mux_sel_o[CH_W-1];
	endproperty
	a_ref_kind: assert property (p_ref_kind)
		else $error("wrong reference mode for channel kind");

	property p_count_down;
		(state == ST_PACE && go_load && counting) |=> remain == $past(remain) - 1'b1;
	endproperty
	a_count_down: assert property (p_count_down)
		else $error("sample counter did not decrement");

	property p_irq;
		(int_stat & int_mask) != '0 |=> irq_o;
	endproperty
	a_irq: assert property (p_irq)
		else $error("interrupt not raised");
endmodule

// [testbench/aas_conv_model.sv]
// Converter model: answers each start with one 16-bit code
module aas_conv_model (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        srst_i,
	// Converter handshake
	input  wire logic        conv_start_i,
	output logic             conv_done_o,
	output logic      [15:0] conv_code_o
);
	logic [1:0]  dly;
	logic [15:0] seq;

	// Three cycles from start to done; code lines toggle when not valid
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			dly         <= 2'h0;
			seq         <= 16'hC000;
			conv_done_o <= 1'b0;
			conv_code_o <= 16'h0000;
		end else begin
			dly         <= {dly[0], conv_start_i};
			conv_done_o <= dly[1];
			conv_code_o <= dly[1] ? seq : ~conv_code_o;
			if (dly[1]) begin
				seq <= seq + 16'h0001;
			end
		end
	end
endmodule

// [testbench/aas_sequencer_test.sv]
// Register-level bench of the acquisition sequencer
module aas_sequencer_test;
	timeunit 1ns;
	timeprecision 1ns;
	import aas_pkg::*;
	logic clk_i = 0, srst_i = 1, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, beg = 0, hld = 0;
	logic [1:0]  pn = 2'h0;
	logic [7:0]  awa = 8'h00, ara = 8'h00;
	logic [31:0] wd = 32'h0, v;
	logic [1:0]  r;
	logic [6:0]  lcfg;
	wire logic awr, wrd, bv, arr, rv, gl, cs, cd, dma, irq, refm;
	wire logic [1:0] br, rr, rng;
	wire logic [3:0] mux;
	wire logic [15:0] code;
	wire logic [31:0] rdat;
	int bad_count = 0, num_checks = 0, cyc = 0;

	aas_sequencer aas_sequencer_i (.clk_i(clk_i), .srst_i(srst_i), .s_axi_awaddr_i(awa),
		.s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd),
		.s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrd), .s_axi_bresp_o(br),
		.s_axi_bvalid_o(bv), .s_axi_bready_i(bre), .s_axi_araddr_i(ara),
		.s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_rdata_o(rdat),
		.s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(rre),
		.acquisition_begin_trigger_i(beg), .pre_post_split_trigger_i(pn[0]),
		.acquisition_hold_trigger_i(hld), .sample_pacing_clock_i(pn[1]), .mux_sel_o(mux),
		.gain_range_o(rng), .reference_mode_setting_o(refm), .gain_load_o(gl),
		.conv_start_o(cs), .conv_done_i(cd), .conv_code_i(code), .dma_req_o(dma), .irq_o(irq));
	aas_conv_model aas_conv_model_i (.clk_i(clk_i), .srst_i(srst_i), .conv_start_i(cs),
		.conv_done_o(cd), .conv_code_o(code));

	initial begin
		forever #5 clk_i = ~clk_i;
	end
	// Last channel setup presented to the gain stage
	always @(negedge clk_i) if (gl === 1'b1) lcfg = {refm, rng, mux};
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			complete_run();
		end
	end

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ha, hw, da, dw;
		da = 0;
		dw = 0;
		@(posedge clk_i);
		awa <= a;
		wd  <= d;
		awv <= 1'b1;
		wv  <= 1'b1;
		bre <= 1'b1;
		while (!(da && dw)) begin
			@(negedge clk_i);
			ha = awv & awr;
			hw = wv & wrd;
			@(posedge clk_i);
			if (ha) awv <= 1'b0;
			if (hw) wv <= 1'b0;
			da = da | ha;
			dw = dw | hw;
		end
		do begin
			@(negedge clk_i);
			ha = bv;
			@(posedge clk_i);
		end while (ha !== 1'b1);
		bre <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] s);
		logic h;
		@(posedge clk_i);
		ara <= a;
		arv <= 1'b1;
		rre <= 1'b1;
		do begin
			@(negedge clk_i);
			h = arv & arr;
			@(posedge clk_i);
			if (h) arv <= 1'b0;
		end while (h !== 1'b1);
		do begin
			@(negedge clk_i);
			h = rv;
			d = rdat;
			s = rr;
			@(posedge clk_i);
		end while (h !== 1'b1);
		rre <= 1'b0;
	endtask
	task automatic poll(input logic [7:0] a, input int b, input logic val);
		do rd(a, v, r); while (v[b] !== val);
	endtask
	// Pulse of split (0) or pacing (1) pin, long enough for the synchroniser
	task automatic pulse(input int b);
		pn[b] <= 1'b1;
		repeat (6) @(posedge clk_i);
		pn[b] <= 1'b0;
		repeat (6) @(posedge clk_i);
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	initial begin
		repeat (3) @(posedge clk_i);
		srst_i <= 1'b0;
		rd(OFF_COUNT, v, r); chk("count", 32'h1, v);
		rd(OFF_PACE, v, r); chk("pace", 32'h63, v);
		rd(8'h3C, v, r); chk("unmapped", {30'h0, RESP_SLVERR}, {30'h0, r});
		// Software-timed conversion of the ground self check channel
		wr(OFF_SCAN, {25'h0, REF_SE, 2'h1, CH_GND_SELF});
		wr(OFF_CMD, 32'h4);
		poll(OFF_ISTAT, INT_SAMPLE, 1'b1);
		chk("load", {25'h0, REF_SE, 2'h1, CH_GND_SELF}, {25'h0, lcfg});
		rd(OFF_DATA, v, r); chk("code0", 32'hC000, v);
		rd(OFF_DATA, v, r); chk("empty", 32'h0, v);
		// Finite run of two scans started by the trigger pin
		wr(OFF_ISTAT, 32'h1F); wr(OFF_IMASK, 32'h2);
		wr(OFF_SCAN + 8'h04, {25'h0, REF_DIFFERENTIAL_INPUT, 2'h2, 4'h3});
		wr(OFF_SLEN, 32'h2); wr(OFF_COUNT, 32'h2); wr(OFF_PACE, 32'h4);
		wr(OFF_CTRL, {30'h0, MODE_FIN}); wr(OFF_CMD, 32'h1);
		beg <= 1'b1;
		repeat (6) @(posedge clk_i);
		beg <= 1'b0;
		poll(OFF_ISTAT, INT_DONE, 1'b1);
		chk("irq set", 32'h1, {31'h0, irq});
		rd(OFF_STATUS, v, r); chk("count", 32'h0400, v & 32'hFF01);
		for (int i = 1; i < 5; i++) begin
			rd(OFF_DATA, v, r); chk("scan", 32'hC000 + i, v);
		end
		chk("load1", {25'h0, REF_DIFFERENTIAL_INPUT, 2'h2, 4'h3}, {25'h0, lcfg});
		wr(OFF_ISTAT, 32'h2); rd(OFF_REMAIN, v, r); chk("remain", 32'h0, v);
		chk("irq clr", 32'h0, {31'h0, irq});
		// Reference trigger with continuous mode is refused
		wr(OFF_CTRL, {28'h0, 2'h2, MODE_CONT});
		wr(OFF_CMD, 32'h1);
		rd(OFF_ISTAT, v, r); chk("cfg err", 32'h10, v & 32'h10);
		// Continuous run overfills the sample FIFO
		wr(OFF_ISTAT, 32'h1F); wr(OFF_IMASK, 32'h1);
		wr(OFF_CTRL, {30'h0, MODE_CONT}); wr(OFF_CMD, 32'h1); wr(OFF_CMD, 32'h8);
		poll(OFF_ISTAT, INT_OVF, 1'b1);
		chk("block", 32'h4, v & 32'h4);
		chk("irq ovf", 32'h1, {31'h0, irq});
		wr(OFF_CMD, 32'h2);
		poll(OFF_STATUS, 0, 1'b0);
		rd(OFF_STATUS, v, r); chk("full", 32'h1004, v & 32'hFF04);
		wr(OFF_ISTAT, 32'h1); rd(OFF_ISTAT, v, r); chk("ovf clr", 32'h0, v & 32'h1);
		chk("irq off", 32'h0, {31'h0, irq});
		// Externally paced finite run: pause, then reference trigger
		wr(OFF_SLEN, 32'h1);
		wr(OFF_COUNT, 32'h1);
		wr(OFF_CTRL, 32'hD);
		wr(OFF_CMD, 32'h1);
		hld <= 1'b1;
		wr(OFF_CMD, 32'h8);
		pulse(1);
		hld <= 1'b0;
		rd(OFF_ISTAT, v, r);
		chk("held", 32'h0, v & 32'h3);
		pulse(1);
		poll(OFF_ISTAT, INT_OVF, 1'b1);
		rd(OFF_REMAIN, v, r);
		chk("pre split", 32'h1, v);
		pulse(0);
		pulse(1);
		poll(OFF_ISTAT, INT_DONE, 1'b1);
		rd(OFF_STATUS, v, r);
		chk("split seen", 32'h8, v & 32'h9);
		rd(OFF_REMAIN, v, r);
		chk("post split", 32'h0, v);
		wr(OFF_CTRL, 32'h11);
		rd(OFF_CTRL, v, r);
		chk("ctrl", 32'h11, v);
		chk("dma", 32'h1, {31'h0, dma});
		complete_run();
	end
endmodule
